// >>> pfs_map.svh
// Register indices, field positions, pad indices and timing counts.
// Assumes it is included by bare name in every file that needs them.
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------
`define PFS_IDX_AUX 8'ha2
`define PFS_IDX_PT4 8'hbb
`define PFS_IDX_OPT 8'hc0

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define PFS_AUX_PTR 0
`define PFS_AUX_SPARE 3
`define PFS_AUX_RELOC 7
`define PFS_PT4_B4 4
`define PFS_PT4_B5 5
`define PFS_PT4_B6 6
`define PFS_OPT_RST_LARGE 0
`define PFS_OPT_RST_SMALL 1
`define PFS_OPT_CLK_T0 2
`define PFS_OPT_CLK_T1 3
`define PFS_OPT_CLK_BAUD 4

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define PFS_RST_PT4 3'h0
`define PFS_RST_OPT 5'h00

// ----------------------------------------------------------------------
// Pad indices in the pad vectors.
// ----------------------------------------------------------------------
`define PFS_PADS 12
`define PFS_PAD_P4_4 0
`define PFS_PAD_P4_5 1
`define PFS_PAD_P4_6 2
`define PFS_PAD_P4_7 3
`define PFS_PAD_P3_6 4
`define PFS_PAD_P3_0 5
`define PFS_PAD_P3_1 6
`define PFS_PAD_P1_6 7
`define PFS_PAD_P1_7 8
`define PFS_PAD_P3_4 9
`define PFS_PAD_P3_5 10
`define PFS_PAD_P1_0 11

// ----------------------------------------------------------------------
// Timing counts.
// ----------------------------------------------------------------------
`define PFS_WAKE_CLOCKS 32768

`endif

// >>> pfs_pkg.sv
// Types shared by the pin function select block.
// Assumes pfs_map.svh supplies the widths used here.
`include "pfs_map.svh"

package pfs_pkg;

  // ----------------------------------------------------------------------
  // Wake-up delay states.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PFS_WK_IDLE = 2'b00,
    PFS_WK_COUNT = 2'b01
  } pfs_wake_e;

  typedef struct packed {
    pfs_wake_e state;
    logic [15:0] count;
  } pfs_wake_s;

  typedef struct packed {
    logic [`PFS_PADS-1:0] ff1;
    logic [`PFS_PADS-1:0] ff2;
    logic [`PFS_PADS-1:0] ff3;
    logic [`PFS_PADS-1:0] level;
  } pfs_sync_s;

  typedef struct packed {
    logic [2:0] pt4_sel;
    logic reloc;
    logic spare;
    logic ptr_sel;
    logic [4:0] opt;
    logic dp_wr;
    logic [7:0] dp_idx;
    logic [31:0] rdata;
  } pfs_main_s;

endpackage : pfs_pkg

// >>> pfs_pad_sync.sv
// Three-stage synchroniser with agreement filter for the pad inputs.
// Assumes the pads are asynchronous to i_clock.
`include "pfs_map.svh"
`timescale 1ns/1ps

module pfs_pad_sync (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [`PFS_PADS-1:0] i_pad,
  output logic [`PFS_PADS-1:0] o_level
);

  pfs_pkg::pfs_sync_s st_r;
  pfs_pkg::pfs_sync_s st_nxt;

  // The first stage feeds only the second; a change is accepted once the
  // second and third stages agree, which rejects one-cycle glitches.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ff1 = i_pad;
    st_nxt.ff2 = st_r.ff1;
    st_nxt.ff3 = st_r.ff2;
    for (int i = 0; i < `PFS_PADS; i++)
    begin
      if (st_r.ff2[i] == st_r.ff3[i])
      begin
        st_nxt.level[i] = st_r.ff3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.level;

endmodule : pfs_pad_sync

// >>> pfs_wake_delay.sv
// Holds the processor for a fixed number of clocks after a wake-up.
// Assumes i_wake is a one-cycle pulse on i_clock.
`include "pfs_map.svh"
`timescale 1ns/1ps

module pfs_wake_delay #(
  parameter logic [15:0] WAKE_CLOCKS = 16'(`PFS_WAKE_CLOCKS)
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wake,
  output logic o_cpu_hold
);

  pfs_pkg::pfs_wake_s st_r;
  pfs_pkg::pfs_wake_s st_nxt;

  // A wake pulse while already counting is ignored, so the delay is
  // never stretched by a second wake source.
  always_comb
  begin
    st_nxt = st_r;
    case (st_r.state)
      pfs_pkg::PFS_WK_IDLE:
      begin
        if (i_wake)
        begin
          st_nxt.state = pfs_pkg::PFS_WK_COUNT;
          st_nxt.count = 16'h0000;
        end
      end
      pfs_pkg::PFS_WK_COUNT:
      begin
        if (st_r.count >= WAKE_CLOCKS - 16'h0001)
        begin
          st_nxt.state = pfs_pkg::PFS_WK_IDLE;
        end
        else
        begin
          st_nxt.count = st_r.count + 16'h0001;
        end
      end
      default:
      begin
        st_nxt.state = pfs_pkg::PFS_WK_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_cpu_hold = (st_r.state == pfs_pkg::PFS_WK_COUNT);

endmodule : pfs_wake_delay

// >>> pfs_pin_select.sv
// Pin function select: port-4 switch, auxiliary control and option
// registers on AHB-Lite, the pad multiplexer and the wake-up delay.
// Assumes a single AHB-Lite master, word transfers, and pads that are
// asynchronous to i_clock.
//
// Chosen here: the AHB-Lite interface to the registers.
`include "pfs_map.svh"
`timescale 1ns/1ps

module pfs_pin_select #(
  parameter logic [15:0] WAKE_CLOCKS = 16'(`PFS_WAKE_CLOCKS),
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [`PFS_PADS-1:0] i_pad_in,
  output logic [`PFS_PADS-1:0] o_pad_out,
  output logic [`PFS_PADS-1:0] o_pad_oe,
  output logic [`PFS_PADS-1:0] o_pad_pull_up,
  input wire logic [`PFS_PADS-1:0] i_gpio_out,
  input wire logic [`PFS_PADS-1:0] i_gpio_oe,
  output logic [`PFS_PADS-1:0] o_gpio_in,
  input wire logic i_ale,
  input wire logic i_serial_txd,
  output logic o_serial_rxd,
  input wire logic i_timer_zero_pin_clk,
  input wire logic i_timer_one_pin_clk,
  input wire logic i_baud_timer_clk,
  output logic o_pointer_select,
  output logic o_pin_reset,
  output logic o_external_clock_required,
  input wire logic i_wake,
  output logic o_cpu_hold
);

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  pfs_pkg::pfs_main_s st_r;
  pfs_pkg::pfs_main_s st_nxt;
  logic [`PFS_PADS-1:0] pad_level;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic [7:0] aux_view;
  logic [7:0] pt4_view;
  logic [7:0] opt_view;
  logic reset_io;

  // Byte address to register index; anything off the word grid misses.
  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction : word_index

  // True when the index names one of the implemented registers.
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == `PFS_IDX_AUX) || (idx == `PFS_IDX_PT4) ||
                (idx == `PFS_IDX_OPT);
  endfunction : is_mapped

  // ----------------------------------------------------------------------
  // Submodules.
  // ----------------------------------------------------------------------
  pfs_pad_sync u_sync (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_pad(i_pad_in),
    .o_level(pad_level)
  );

  pfs_wake_delay #(
    .WAKE_CLOCKS(WAKE_CLOCKS)
  ) u_wake (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_wake(i_wake),
    .o_cpu_hold(o_cpu_hold)
  );

  // ----------------------------------------------------------------------
  // Address phase qualification.
  // ----------------------------------------------------------------------

  // Only word transfers with NONSEQ or SEQ to the upper 22 address bits of
  // zero are taken; others complete with OKAY and no effect.
  assign addr_idx = word_index(i_haddr);
  assign addr_ok = i_hsel && i_hready && i_htrans[1] &&
                   (i_hsize == 3'h2) && (i_haddr[31:10] == 22'h000000) &&
                   (i_haddr[1:0] == 2'h0);

  // ----------------------------------------------------------------------
  // Register update and read data.
  // ----------------------------------------------------------------------

  // The write of a data phase lands first, and the read data for a new
  // address phase is taken from the updated copy, so a read straight
  // after a write already sees the new value.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.dp_wr = 1'b0;
    if (st_r.dp_wr)
    begin
      case (st_r.dp_idx)
        `PFS_IDX_AUX:
        begin
          st_nxt.reloc = i_hwdata[`PFS_AUX_RELOC];
          st_nxt.spare = i_hwdata[`PFS_AUX_SPARE];
          st_nxt.ptr_sel = i_hwdata[`PFS_AUX_PTR];
        end
        `PFS_IDX_PT4:
        begin
          // Bits 7 and 3..0 are not stored.
          st_nxt.pt4_sel = i_hwdata[`PFS_PT4_B6:`PFS_PT4_B4];
        end
        `PFS_IDX_OPT:
        begin
          st_nxt.opt = i_hwdata[4:0];
        end
        default:
        begin
          st_nxt.opt = st_r.opt;
        end
      endcase
    end
    if (addr_ok)
    begin
      st_nxt.dp_wr = i_hwrite && is_mapped(addr_idx);
      st_nxt.dp_idx = addr_idx;
    end
    st_nxt.rdata = 32'h00000000;
    if (addr_ok && !i_hwrite)
    begin
      case (addr_idx)
        `PFS_IDX_AUX:
        begin
          st_nxt.rdata[`PFS_AUX_RELOC] = st_nxt.reloc;
          st_nxt.rdata[`PFS_AUX_SPARE] = st_nxt.spare;
          st_nxt.rdata[`PFS_AUX_PTR] = st_nxt.ptr_sel;
        end
        `PFS_IDX_PT4:
        begin
          st_nxt.rdata[`PFS_PT4_B6:`PFS_PT4_B4] = st_nxt.pt4_sel;
        end
        `PFS_IDX_OPT:
        begin
          st_nxt.rdata[4:0] = st_nxt.opt;
        end
        default:
        begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // State register; the select bits reset to their pin-default values.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r <= '0;
      st_r.pt4_sel <= `PFS_RST_PT4;
      st_r.opt <= `PFS_RST_OPT;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Zero-wait slave: every transfer completes in its first data cycle.
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = st_r.rdata;

  // ----------------------------------------------------------------------
  // Pad multiplexer.
  // ----------------------------------------------------------------------

  // Views kept only for readability of the mux and the input logic below.
  assign aux_view = {st_r.reloc, 3'h0, st_r.spare, 2'h0, st_r.ptr_sel};
  assign pt4_view = {1'b0, st_r.pt4_sel, 4'h0};
  assign opt_view = {3'h0, st_r.opt};

  // A freed reset pin leaves the device without its reset, and the
  // internal oscillator is then not allowed, hence the flag out.
  assign reset_io = SMALL_PACKAGE ? opt_view[`PFS_OPT_RST_SMALL] :
                                    opt_view[`PFS_OPT_RST_LARGE];
  assign o_external_clock_required = reset_io;

  // Every pad defaults to general I/O, then each special function
  // overrides its own pads; later overrides win where they overlap.
  always_comb
  begin
    o_pad_out = i_gpio_out;
    o_pad_oe = i_gpio_oe;
    o_pad_pull_up = '0;
    // Unselected P4.4 and P4.6 float on a weak pull-up with no function; unselected P4.5 drives the address strobe.
    if (!pt4_view[`PFS_PT4_B4])
    begin
      o_pad_out[`PFS_PAD_P4_4] = 1'b0;
      o_pad_oe[`PFS_PAD_P4_4] = 1'b0;
      o_pad_pull_up[`PFS_PAD_P4_4] = 1'b1;
    end
    if (!pt4_view[`PFS_PT4_B5])
    begin
      o_pad_out[`PFS_PAD_P4_5] = i_ale;
      o_pad_oe[`PFS_PAD_P4_5] = 1'b1;
    end
    if (!pt4_view[`PFS_PT4_B6])
    begin
      o_pad_out[`PFS_PAD_P4_6] = 1'b0;
      o_pad_oe[`PFS_PAD_P4_6] = 1'b0;
      o_pad_pull_up[`PFS_PAD_P4_6] = 1'b1;
    end
    // A reset pin in its reset role is an input only.
    if (!opt_view[`PFS_OPT_RST_LARGE])
    begin
      o_pad_out[`PFS_PAD_P4_7] = 1'b0;
      o_pad_oe[`PFS_PAD_P4_7] = 1'b0;
    end
    if (!opt_view[`PFS_OPT_RST_SMALL])
    begin
      o_pad_out[`PFS_PAD_P3_6] = 1'b0;
      o_pad_oe[`PFS_PAD_P3_6] = 1'b0;
    end
    // Serial pair on port 3 or relocated to port 1.
    if (aux_view[`PFS_AUX_RELOC])
    begin
      o_pad_out[`PFS_PAD_P1_7] = i_serial_txd;
      o_pad_oe[`PFS_PAD_P1_7] = 1'b1;
      o_pad_oe[`PFS_PAD_P1_6] = 1'b0;
    end
    else
    begin
      o_pad_out[`PFS_PAD_P3_1] = i_serial_txd;
      o_pad_oe[`PFS_PAD_P3_1] = 1'b1;
      o_pad_oe[`PFS_PAD_P3_0] = 1'b0;
    end
    // Programmable clock outputs.
    if (opt_view[`PFS_OPT_CLK_T0])
    begin
      o_pad_out[`PFS_PAD_P3_4] = i_timer_zero_pin_clk;
      o_pad_oe[`PFS_PAD_P3_4] = 1'b1;
    end
    if (opt_view[`PFS_OPT_CLK_T1])
    begin
      o_pad_out[`PFS_PAD_P3_5] = i_timer_one_pin_clk;
      o_pad_oe[`PFS_PAD_P3_5] = 1'b1;
    end
    if (opt_view[`PFS_OPT_CLK_BAUD])
    begin
      o_pad_out[`PFS_PAD_P1_0] = i_baud_timer_clk;
      o_pad_oe[`PFS_PAD_P1_0] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Inputs back to the core.
  // ----------------------------------------------------------------------

  // Receive follows the selected pin pair.
  assign o_serial_rxd = aux_view[`PFS_AUX_RELOC] ?
                        pad_level[`PFS_PAD_P1_6] :
                        pad_level[`PFS_PAD_P3_0];

  // Reset request only while the pin still has its reset role; the
  // package parameter picks which of the two pins is the reset pin.
  assign o_pin_reset = SMALL_PACKAGE ?
    (!opt_view[`PFS_OPT_RST_SMALL] && pad_level[`PFS_PAD_P3_6]) :
    (!opt_view[`PFS_OPT_RST_LARGE] && pad_level[`PFS_PAD_P4_7]);

  // Filtered pad levels go to the core as the port input values.
  assign o_gpio_in = pad_level;

  // Active data pointer choice for the core.
  assign o_pointer_select = st_r.ptr_sel;

endmodule : pfs_pin_select

// >>> pfs_pin_select_monitor.sv
// Concurrent checks on the ports of the pin function select block.
// Assumes a bind onto pfs_pin_select that passes WAKE_CLOCKS on.
`include "pfs_map.svh"
`timescale 1ns/1ps

module pfs_pin_select_monitor #(
  parameter logic [15:0] WAKE_CLOCKS = 16'(`PFS_WAKE_CLOCKS)
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic [`PFS_PADS-1:0] o_pad_out,
  input wire logic [`PFS_PADS-1:0] o_pad_oe,
  input wire logic [`PFS_PADS-1:0] o_pad_pull_up,
  input wire logic [`PFS_PADS-1:0] i_gpio_oe,
  input wire logic i_ale,
  input wire logic i_serial_txd,
  input wire logic o_pointer_select,
  input wire logic o_pin_reset,
  input wire logic o_external_clock_required,
  input wire logic i_wake,
  input wire logic o_cpu_hold
);
  // -------
  // Helpers
  // -------
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic rd_req;
  int hold_cnt_r;

  // A read address phase; only these may leave data on the bus.
  assign rd_req = i_hsel && i_hready && i_htrans[1] && !i_hwrite;

  // Length of the current hold, so the full span can be judged at its end.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      hold_cnt_r <= 0;
    else
      hold_cnt_r <= o_cpu_hold ? hold_cnt_r + 1 : 0;
  end

  sequence s_aux_read;
    rd_req && i_haddr == {22'h0, `PFS_IDX_AUX, 2'b00};
  endsequence

  // ----------
  // Assertions
  // ----------
  a_bus_always_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus slave stalled or answered with an error");
  a_read_data_idle: assert property (!rd_req |=> o_hrdata == 32'h0)
    else $error("read data present without a read");
  a_unused_bits_zero: assert property
    (s_aux_read |=> (o_hrdata & 32'hffff_ff76) == 32'h0)
    else $error("unimplemented auxiliary bits read nonzero");
  a_pointer_readback: assert property
    (s_aux_read |=> o_hrdata[0] == o_pointer_select)
    else $error("pointer select output differs from its register");
  a_idle_pad_quiet: assert property (o_pad_pull_up[0] |-> !o_pad_oe[0])
    else $error("idle pulled-up pad is also driven");
  a_strobe_on_pad: assert property
    (o_pad_oe[1] && !i_gpio_oe[1] |-> o_pad_out[1] == i_ale)
    else $error("strobe pad does not carry the address strobe");
  a_transmit_driven: assert property
    ((o_pad_oe[6] && o_pad_out[6] == i_serial_txd) ||
     (o_pad_oe[8] && o_pad_out[8] == i_serial_txd))
    else $error("transmit data reaches no serial pad");
  a_freed_reset_pin: assert property
    (o_external_clock_required |-> !o_pin_reset)
    else $error("freed reset pin still asserts reset");
  a_wake_hold_cause: assert property ($rose(o_cpu_hold) |-> $past(i_wake))
    else $error("processor hold began without a wake pulse");
  a_wake_hold_span: assert property
    ($fell(o_cpu_hold) |-> hold_cnt_r == int'(WAKE_CLOCKS))
    else $error("processor hold lasted the wrong number of clocks");
endmodule : pfs_pin_select_monitor

bind pfs_pin_select pfs_pin_select_monitor #(.WAKE_CLOCKS(WAKE_CLOCKS)) u_mon (
  .i_clock, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready,
  .o_hreadyout, .o_hresp, .o_hrdata, .o_pad_out, .o_pad_oe, .o_pad_pull_up,
  .i_gpio_oe, .i_ale, .i_serial_txd, .o_pointer_select, .o_pin_reset,
  .o_external_clock_required, .i_wake, .o_cpu_hold
);

// >>> tb.sv
// Self-checking bench for the pin function select block.
// Assumes the block is the only slave on its bus; wake count is shortened.
`include "pfs_map.svh"
`timescale 1ns/1ps

module tb;
  // -------
  // Signals
  // -------
  localparam logic [31:0] A_AUX = {22'h0, `PFS_IDX_AUX, 2'b00};
  localparam logic [31:0] A_PT4 = {22'h0, `PFS_IDX_PT4, 2'b00};
  localparam logic [31:0] A_OPT = {22'h0, `PFS_IDX_OPT, 2'b00};
  localparam int WAKE = 8;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0;
  logic i_hready;
  logic [11:0] i_pad_in = 12'h0;
  logic [11:0] i_gpio_out = 12'h0;
  logic [11:0] i_gpio_oe = 12'h0;
  logic i_ale = 1'b1;
  logic i_serial_txd = 1'b0;
  logic i_wake = 1'b0;
  logic i_timer_zero_pin_clk = 1'b0;
  logic i_timer_one_pin_clk = 1'b0;
  logic i_baud_timer_clk = 1'b0;
  logic o_hreadyout, o_hresp, o_serial_rxd, o_pointer_select, o_cpu_hold;
  logic o_pin_reset, o_external_clock_required;
  logic [31:0] o_hrdata;
  logic [11:0] o_pad_out, o_pad_oe, o_pad_pull_up, o_gpio_in;
  int failures = 0;
  int checks = 0;

  // The single slave's ready is the bus ready.
  assign i_hready = o_hreadyout;

  // Core clock, 20 ns period.
  always #10 i_clock = ~i_clock;

  pfs_pin_select #(.WAKE_CLOCKS(16'(WAKE)), .SMALL_PACKAGE(1'b0)) uut (
    .i_clock, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_pad_in,
    .o_pad_out, .o_pad_oe, .o_pad_pull_up, .i_gpio_out, .i_gpio_oe,
    .o_gpio_in, .i_ale, .i_serial_txd, .o_serial_rxd, .i_timer_zero_pin_clk,
    .i_timer_one_pin_clk, .i_baud_timer_clk, .o_pointer_select, .o_pin_reset,
    .o_external_clock_required, .i_wake, .o_cpu_hold
  );

  // -------------
  // Shared tasks
  // -------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One single transfer; waits on ready, never on a fixed count.
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    do @(posedge i_clock); while (i_hready !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= d;
    do @(posedge i_clock); while (i_hready !== 1'b1);
    q = o_hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd_check

  // Outputs are judged mid-cycle so that edge updates have landed.
  task automatic look(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask : look

  task automatic do_reset;
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
  endtask : do_reset

  task automatic report_and_stop;
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // ---------
  // Scenarios
  // ---------
  task automatic t_reset_state;
    look(0);
    check(32'({o_pad_oe[2], o_pad_oe[0], o_pad_pull_up[2],
               o_pad_pull_up[0]}), 32'h3);
    check(32'({o_pad_oe[1], o_pad_out[1], o_pointer_select}), 32'h6);
    rd_check(A_AUX, 32'h0);
    rd_check(A_PT4, 32'h0);
  endtask : t_reset_state

  task automatic t_port4;
    wr(A_PT4, 32'hffff_ffff);
    rd_check(A_PT4, 32'h70);
    i_gpio_out <= 12'h005;
    i_gpio_oe <= 12'h007;
    look(1);
    check(32'({o_pad_oe[2:0], o_pad_out[2:0]}), 32'h3d);
    wr(A_PT4, 32'h0);
    // The general I/O value differs from the strobe, so the mux shows.
    i_ale <= 1'b0;
    i_gpio_out <= 12'h002;
    look(0);
    check(32'({o_pad_oe[1], o_pad_out[1]}), 32'h2);
  endtask : t_port4

  task automatic t_aux;
    wr(A_AUX, 32'hffff_ffff);
    rd_check(A_AUX, 32'h89);
    i_serial_txd <= 1'b1;
    i_pad_in <= 12'h080;
    look(6);
    check(32'({o_pointer_select, o_serial_rxd, o_pad_oe[8],
               o_pad_out[8]}), 32'hf);
    wr(A_AUX, 32'h08);
    rd_check(A_AUX, 32'h08);
    look(2);
    check(32'({o_pointer_select, o_serial_rxd, o_pad_oe[6],
               o_pad_out[6]}), 32'h3);
  endtask : t_aux

  task automatic t_reset_pin;
    @(posedge i_clock);
    i_pad_in <= 12'h008;
    look(6);
    check(32'({o_pin_reset, o_external_clock_required}), 32'h2);
    check(32'(o_gpio_in), 32'h008);
    wr(A_OPT, 32'h01);
    rd_check(A_OPT, 32'h01);
    look(6);
    check(32'({o_pin_reset, o_external_clock_required}), 32'h1);
    wr(A_OPT, 32'h0);
    // The small-package reset pin is freed only by its own option bit.
    i_gpio_oe <= 12'h017;
    wr(A_OPT, 32'h02);
    look(0);
    check(32'({o_pad_oe[4], o_external_clock_required}), 32'h2);
    wr(A_OPT, 32'h0);
    look(0);
    check(32'(o_pad_oe[4]), 32'h0);
  endtask : t_reset_pin

  // Gpio values are the inverse of the clocks, so an override shows.
  task automatic t_clock_out;
    wr(A_OPT, 32'h1c);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clock);
      {i_baud_timer_clk, i_timer_one_pin_clk, i_timer_zero_pin_clk}
        <= k ? 3'b010 : 3'b101;
      i_gpio_out <= k ? 12'ha00 : 12'h400;
      look(0);
      check(32'({o_pad_oe[11:9], o_pad_out[11:9]}), k ? 32'h3a : 32'h3d);
    end
    wr(A_OPT, 32'h0);
    look(0);
    check(32'(o_pad_out[11:9]), 32'h5);
  endtask : t_clock_out

  // A second wake pulse during the hold must not stretch it; the hold is
  // sampled mid-cycle, where it has settled.
  task automatic t_wake;
    int n;
    n = 0;
    @(posedge i_clock);
    i_wake <= 1'b1;
    @(posedge i_clock);
    i_wake <= 1'b0;
    for (int k = 0; k < 20; k++)
    begin
      @(negedge i_clock);
      if (o_cpu_hold === 1'b1)
        n++;
      @(posedge i_clock);
      i_wake <= (k == 2);
    end
    check(32'(n), 32'(WAKE));
  endtask : t_wake

  task automatic t_refused;
    wr(32'h0000_0100, 32'hff);
    rd_check(32'h0000_0100, 32'h0);
    i_hsize <= 3'h0;
    wr(A_AUX, 32'h81);
    i_hsize <= 3'h2;
    rd_check(A_AUX, 32'h08);
    wr(A_PT4, 32'h70);
    do_reset;
    rd_check(A_PT4, 32'h0);
    rd_check(A_AUX, 32'h0);
  endtask : t_refused

  // Main sequence.
  initial
  begin
    do_reset;
    t_reset_state;
    t_port4;
    t_aux;
    t_reset_pin;
    t_clock_out;
    t_wake;
    t_refused;
    report_and_stop;
  end

  // Watchdog, far beyond the fewer than two hundred cycles the run needs.
  initial
  begin
    #100us;
    failures++;
    report_and_stop;
  end
endmodule : tb
